// file: design/nos_consts.vh
// Constants for the NAND operation sequencer host controller
// Assumes inclusion by bare name from design files
`ifndef NOS_CONSTS_VH
`define NOS_CONSTS_VH
// APB register offsets (byte addresses)
`define NOS_REG_CTRL 12'h000
`define NOS_REG_ADDR 12'h004
`define NOS_REG_WDATA 12'h008
`define NOS_REG_RDATA 12'h00c
`define NOS_REG_STATUS 12'h010
`define NOS_REG_CFG 12'h014
// Control fields
`define NOS_CTRL_START 8
`define NOS_CTRL_OP_LO 0
`define NOS_CTRL_OP_HI 3
`define NOS_CTRL_CMD_LO 16
`define NOS_CTRL_CMD_HI 23
// Operation codes
`define NOS_OP_CMD 4'h0
`define NOS_OP_ADDR 4'h1
`define NOS_OP_WRITE 4'h2
`define NOS_OP_READ 4'h3
`define NOS_OP_WAITRDY 4'h4
// Device command codes
`define NOS_CMD_READ1 8'h00
`define NOS_CMD_READ2 8'h01
`define NOS_CMD_READ3 8'h50
`define NOS_CMD_SERIAL_IN 8'h80
`define NOS_CMD_PROGRAM 8'h10
`define NOS_CMD_DUMMY 8'h11
`define NOS_CMD_MULTI 8'h15
`define NOS_CMD_ERASE_SETUP 8'h60
`define NOS_CMD_ERASE_GO 8'hd0
`define NOS_CMD_STATUS1 8'h70
`define NOS_CMD_STATUS2 8'h71
`define NOS_CMD_RESET 8'hff
// Status byte fields
`define NOS_ST_FAIL 0
`define NOS_ST_G0 1
`define NOS_ST_G3 4
`define NOS_ST_SPARE 5
`define NOS_ST_READY 6
`define NOS_ST_UNPROT 7
// Address layout
`define NOS_ADDR_CYCLES 3'd4
`define NOS_GROUP_LO 13
`define NOS_GROUP_HI 14
`define NOS_PAGES_PER_BLOCK 6'd32
// Strobe timing: cycles of the S_LOW and S_HIGH phases at 40 MHz; S_SAMPLE lasts two more
`define NOS_PHASE_CYCLES 4'd2
`define NOS_CFG_RESET 8'h00
`endif

// file: design/nos_pin_sync.v
// Two flop synchroniser for device pins
// Assumes asynchronous inputs and one system clock
`timescale 1ns/1ps
module nos_pin_sync #(
  parameter WIDTH = 9
) (
  input wire clock,
  input wire rstn,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      stage1 <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // nos_pin_sync

// file: design/nos_host.v
// Host controller that drives a byte wide NAND flash over its strobes
// Assumes APB software access, one 40 MHz clock, device pins asynchronous
// Notes on behaviour
// - Command 00H selects first read mode with pointer in lower half.
// - Crossing a block boundary needs fresh read command and address.
// - Pass/fail bit counts only while device reports ready.
// - Program starts on 10H after serial input, address and data.
// - Multi-block groups separated by 11H; 15H or 10H programs them.
// - Full sequence repeats load and 15H 31 times, ends with 10H.
// - At most one block per group, same page in each step; the host records groups in groupsUsed but flags neither rule.
// - During multi-block program only sequence, status or reset commands.
// - Early 10H ends multi-block program; status accumulates up to it.
// - After final 10H only ready bit valid until device ready.
// - Address sent over four address cycles, low byte first.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "nos_consts.vh"
module nos_host (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg chipEnableN,
  output reg cmdLatch,
  output reg addrLatch,
  output reg writeStrobeN,
  output reg read_strobe_n,
  output reg writeProtectN,
  output reg [7:0] bytePortOut,
  output reg bytePortOe,
  input wire [7:0] bytePortIn,
  input wire ready_busy_n
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [8:0] pinSync;
  nos_pin_sync #(.WIDTH(9)) uSync (
    .clock(clock),
    .rstn(rstn),
    .din({ready_busy_n, bytePortIn}),
    .dout(pinSync)
  );
  wire devReady = pinSync[8];
  wire [7:0] devByte = pinSync[7:0];
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_LOW = 3'd1;
  localparam S_HIGH = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_SAMPLE = 3'd4;
  reg [2:0] state;
  reg [3:0] op;
  reg [7:0] cmdByte;
  reg [31:0] addrWord;
  reg [7:0] wdata;
  reg [7:0] rdata;
  reg [7:0] cfg;
  reg [2:0] addrCount;
  reg [3:0] phase;
  reg busy;
  reg done;
  reg [7:0] lastStatus;
  reg statusMode;
  reg [3:0] groupsUsed;
  reg multiActive;
  reg [5:0] pageStep;
  reg seqError;
  reg eraseActive;
  function isSeqCmd;
    input [7:0] c;
    begin
      isSeqCmd = (c == `NOS_CMD_SERIAL_IN) || (c == `NOS_CMD_PROGRAM) ||
        (c == `NOS_CMD_DUMMY) || (c == `NOS_CMD_MULTI) ||
        (c == `NOS_CMD_STATUS1) || (c == `NOS_CMD_STATUS2) ||
        (c == `NOS_CMD_RESET);
    end
  endfunction
  function isStatusCmd;
    input [7:0] c;
    begin
      isStatusCmd = (c == `NOS_CMD_STATUS1) || (c == `NOS_CMD_STATUS2);
    end
  endfunction
  // ----------------------------------------
  // Status capture
  // ----------------------------------------
  function [7:0] statusClean;
    input [7:0] s;
    begin
      statusClean = s;
      statusClean[`NOS_ST_SPARE] = 1'b0;
      if (!s[`NOS_ST_READY])
        statusClean[`NOS_ST_G3:`NOS_ST_FAIL] = 5'h00;
    end
  endfunction
  wire [1:0] addrGroup = addrWord[`NOS_GROUP_HI:`NOS_GROUP_LO];
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire apbSetup = psel && !penable && !pready;
  wire apbWr = apbSetup && pwrite;
  wire startReq = apbWr && (paddr == `NOS_REG_CTRL) && pwdata[`NOS_CTRL_START] && !busy;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      addrWord <= 32'h00000000;
      wdata <= 8'h00;
      cfg <= `NOS_CFG_RESET;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= 1'b0;
      if (apbSetup)
      begin
        case (paddr)
          `NOS_REG_CTRL: prdata <= {8'h00, cmdByte, 8'h00, 4'h0, op};
          `NOS_REG_ADDR: prdata <= addrWord;
          `NOS_REG_WDATA: prdata <= {24'h000000, wdata};
          `NOS_REG_RDATA: prdata <= {24'h000000, rdata};
          `NOS_REG_STATUS: prdata <= {2'b00, pageStep, lastStatus, 4'h0, groupsUsed,
            3'b000, seqError, multiActive, devReady, done, busy};
          `NOS_REG_CFG: prdata <= {24'h000000, cfg};
          default:
          begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
        if (pwrite)
        begin
          if (paddr == `NOS_REG_ADDR && !busy)
            addrWord <= pwdata;
          if (paddr == `NOS_REG_WDATA && !busy)
            wdata <= pwdata[7:0];
          if (paddr == `NOS_REG_CFG)
            cfg <= pwdata[7:0];
        end
      end
    end
  end
  // ----------------------------------------
  // Strobe sequencer
  // ----------------------------------------
  wire phaseEnd = (phase == `NOS_PHASE_CYCLES - 4'd1);
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      state <= S_IDLE;
      op <= `NOS_OP_CMD;
      cmdByte <= 8'h00;
      rdata <= 8'h00;
      addrCount <= 3'd0;
      phase <= 4'd0;
      busy <= 1'b0;
      done <= 1'b0;
      lastStatus <= 8'h00;
      statusMode <= 1'b0;
      groupsUsed <= 4'h0;
      multiActive <= 1'b0;
      pageStep <= 6'd0;
      seqError <= 1'b0;
      eraseActive <= 1'b0;
      chipEnableN <= 1'b1;
      cmdLatch <= 1'b0;
      addrLatch <= 1'b0;
      writeStrobeN <= 1'b1;
      read_strobe_n <= 1'b1;
      writeProtectN <= 1'b0;
      bytePortOut <= 8'h00;
      bytePortOe <= 1'b0;
    end
    else
    begin
      writeProtectN <= cfg[0];
      if (apbWr && paddr == `NOS_REG_STATUS && pwdata[1])
        done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (startReq)
          begin
            op <= pwdata[`NOS_CTRL_OP_HI:`NOS_CTRL_OP_LO];
            cmdByte <= pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO];
            busy <= 1'b1;
            done <= 1'b0;
            addrCount <= 3'd0;
            phase <= 4'd0;
            chipEnableN <= 1'b0;
            if (pwdata[`NOS_CTRL_OP_HI:`NOS_CTRL_OP_LO] == `NOS_OP_WAITRDY)
              state <= S_WAIT;
            else
              state <= S_LOW;
            if (pwdata[`NOS_CTRL_OP_HI:`NOS_CTRL_OP_LO] == `NOS_OP_CMD)
            begin
              // Track multi-block sequence and flag commands out of order
              if (multiActive && !isSeqCmd(pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO]))
                seqError <= 1'b1;
              if (pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO] == `NOS_CMD_SERIAL_IN)
                multiActive <= 1'b1;
              if (pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO] == `NOS_CMD_MULTI)
              begin
                groupsUsed <= 4'h0;
                pageStep <= pageStep + 6'd1;
                if (pageStep == `NOS_PAGES_PER_BLOCK - 6'd1)
                  seqError <= 1'b1;
              end
              if (pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO] == `NOS_CMD_PROGRAM)
              begin
                multiActive <= 1'b0;
                groupsUsed <= 4'h0;
                pageStep <= 6'd0;
              end
              if (pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO] == `NOS_CMD_ERASE_SETUP)
                eraseActive <= 1'b1;
              if (pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO] == `NOS_CMD_ERASE_GO)
              begin
                groupsUsed <= 4'h0;
                eraseActive <= 1'b0;
              end
              statusMode <= isStatusCmd(pwdata[`NOS_CTRL_CMD_HI:`NOS_CTRL_CMD_LO]);
            end
          end
        end
        S_LOW:
        begin
          phase <= phase + 4'd1;
          if (phase == 4'd0)
          begin
            cmdLatch <= (op == `NOS_OP_CMD);
            addrLatch <= (op == `NOS_OP_ADDR);
            bytePortOe <= (op != `NOS_OP_READ);
            if (op == `NOS_OP_ADDR)
              bytePortOut <= addrWord[8*addrCount +: 8];
            else if (op == `NOS_OP_CMD)
              bytePortOut <= cmdByte;
            else
              bytePortOut <= wdata;
          end
          else if (phase == 4'd1)
          begin
            if (op == `NOS_OP_READ)
              read_strobe_n <= 1'b0;
            else
              writeStrobeN <= 1'b0;
          end
          if (phaseEnd && phase != 4'd0)
          begin
            phase <= 4'd0;
            state <= (op == `NOS_OP_READ) ? S_SAMPLE : S_HIGH;
          end
          else if (phaseEnd)
            phase <= phase + 4'd1;
        end
        S_SAMPLE:
        begin
          phase <= phase + 4'd1;
          if (phase == `NOS_PHASE_CYCLES + 4'd1)
          begin
            rdata <= devByte;
            if (statusMode)
              lastStatus <= statusClean(devByte);
            read_strobe_n <= 1'b1;
            phase <= 4'd0;
            state <= S_HIGH;
          end
        end
        S_HIGH:
        begin
          writeStrobeN <= 1'b1;
          phase <= phase + 4'd1;
          if (phaseEnd)
          begin
            phase <= 4'd0;
            cmdLatch <= 1'b0;
            if (op == `NOS_OP_ADDR && addrCount != `NOS_ADDR_CYCLES - 3'd1)
            begin
              addrCount <= addrCount + 3'd1;
              state <= S_LOW;
              addrLatch <= 1'b0;
            end
            else
            begin
              if (op == `NOS_OP_ADDR && (multiActive || eraseActive))
                groupsUsed[addrGroup] <= 1'b1;
              addrLatch <= 1'b0;
              bytePortOe <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_WAIT:
        begin
          // Wait on ready after program, erase or array read
          phase <= (phase == 4'hf) ? phase : phase + 4'd1;
          if (phase > `NOS_PHASE_CYCLES && devReady)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            phase <= 4'd0;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // nos_host

// file: test/nos_host_properties.sv
// Checker for the flash host pins and APB answer
// Assumes it is bound into nos_host, one clock domain
`timescale 1ns/1ps
// ----
// Properties
// ----
module nos_host_properties (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire chipEnableN,
  input wire cmdLatch,
  input wire addrLatch,
  input wire writeStrobeN,
  input wire read_strobe_n,
  input wire [7:0] bytePortOut,
  input wire bytePortOe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_PREADY: assert property (psel && !penable |=> pready) else $error("late pready");
  AST_SLVERR: assert property (pslverr |-> pready) else $error("stray pslverr");
  AST_LATCHES: assert property (!(cmdLatch && addrLatch)) else $error("two latches");
  AST_STROBES: assert property (writeStrobeN || read_strobe_n) else $error("two strobes");
  AST_WR_DRIVE: assert property (!writeStrobeN |-> bytePortOe && !chipEnableN)
    else $error("write undriven");
  AST_HELD: assert property ($rose(writeStrobeN) |->
    $stable(bytePortOut) && $stable(cmdLatch) && $stable(addrLatch)) else $error("moved");
  AST_RD_FREE: assert property (!read_strobe_n |-> !bytePortOe && !chipEnableN)
    else $error("read contention");
  AST_WE_LOW: assert property ($fell(writeStrobeN) |=> writeStrobeN ##1 writeStrobeN)
    else $error("strobe width");
endmodule // nos_host_properties
bind nos_host nos_host_properties u_chk (
  .clock(clock),
  .rstn(rstn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .chipEnableN(chipEnableN),
  .cmdLatch(cmdLatch),
  .addrLatch(addrLatch),
  .writeStrobeN(writeStrobeN),
  .read_strobe_n(read_strobe_n),
  .bytePortOut(bytePortOut),
  .bytePortOe(bytePortOe)
);

// file: test/nos_flash_model.sv
// Behavioural model of the byte wide flash device
// Assumes strobes from nos_host; failing groups are set by the bench
`timescale 1ns/1ps
// ----
// Device model
// ----
module nos_flash_model #(
  parameter BUSY_NS = 2000
) (
  input wire chipEnableN,
  input wire cmdLatch,
  input wire addrLatch,
  input wire writeStrobeN,
  input wire read_strobe_n,
  input wire writeProtectN,
  input wire [7:0] bytePortOut,
  input wire [3:0] failGroups,
  output logic [7:0] bytePortIn = 8'h00,
  output logic ready_busy_n = 1'b1
);
  logic [7:0] arr [int];
  logic [7:0] pg [0:527];
  logic [7:0] cmd = 8'hff;
  logic [31:0] adr = 32'h0;
  logic [3:0] gf = 4'h0;
  logic multi = 1'b0;
  int nAdr = 0;
  int base = 0;
  int col = 0;
  int page = 0;
  task automatic busy();
    ready_busy_n <= 1'b0;
    ready_busy_n <= #(BUSY_NS) 1'b1;
  endtask
  task automatic load();
    foreach (pg[k])
      pg[k] = arr.exists(page * 528 + k) ? arr[page * 528 + k] : 8'hff;
    busy();
  endtask
  always @(posedge writeStrobeN)
  begin
    if (cmdLatch && !chipEnableN)
    begin
      cmd = bytePortOut;
      nAdr = 0;
      if (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)
        base = (cmd == 8'h00) ? 0 : (cmd == 8'h01) ? 256 : 512;
      if ((cmd == 8'h80 || cmd == 8'h60) && !multi)
        gf = 4'h0;
      if (cmd == 8'h80 || cmd == 8'h60)
        multi = 1'b1;
      if (cmd == 8'h80)
        foreach (pg[k])
          pg[k] = 8'hff;
      if (cmd == 8'h10 || cmd == 8'h11 || cmd == 8'h15)
      begin
        foreach (pg[k])
          arr[page * 528 + k] = pg[k];
        gf[page[6:5]] = gf[page[6:5]] | failGroups[page[6:5]];
      end
      if (cmd == 8'h10 || cmd == 8'hd0)
        multi = 1'b0;
      if (cmd == 8'h10 || cmd == 8'h15 || cmd == 8'hd0)
        busy();
    end
    else if (addrLatch && !chipEnableN)
    begin
      adr[8 * nAdr +: 8] = bytePortOut;
      nAdr++;
      page = adr[24:8];
      col = base + ((base == 512) ? adr[3:0] : adr[7:0]);
      if (nAdr == 4 && cmd == 8'h60)
        gf[page[6:5]] = gf[page[6:5]] | failGroups[page[6:5]];
      if (nAdr == 4 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50))
        load();
    end
    else if (!chipEnableN)
    begin
      pg[col] = bytePortOut;
      col++;
    end
  end
  always @(negedge read_strobe_n)
  begin
    if (cmd == 8'h70 || cmd == 8'h71)
      bytePortIn = {writeProtectN, ready_busy_n, 1'b0, (cmd == 8'h71) ? gf : 4'h0, |gf};
    else
    begin
      bytePortIn = pg[col];
      col++;
      if (col == 528)
      begin
        page++;
        col = (base == 512) ? 512 : 0;
        load();
      end
    end
  end
  // Released port shows a changing value
  always @(posedge read_strobe_n)
    bytePortIn = ~bytePortIn;
endmodule // nos_flash_model

// file: test/testbench.sv
// Bench for the flash host controller over APB
// Assumes nos_host, the flash model, and the checker bound to the host
`timescale 1ns/1ps
`include "nos_consts.vh"
// ----
// Bench
// ----
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] failGroups = 4'h0;
  logic [31:0] prdata, rd;
  logic [7:0] bytePortOut, bytePortIn;
  logic pready, pslverr, err, chipEnableN, cmdLatch, addrLatch, writeStrobeN;
  logic read_strobe_n, writeProtectN, bytePortOe, ready_busy_n;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  nos_host u_dut (
    .clock(clock),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chipEnableN(chipEnableN),
    .cmdLatch(cmdLatch),
    .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN),
    .read_strobe_n(read_strobe_n),
    .writeProtectN(writeProtectN),
    .bytePortOut(bytePortOut),
    .bytePortOe(bytePortOe),
    .bytePortIn(bytePortIn),
    .ready_busy_n(ready_busy_n)
  );
  nos_flash_model u_flash (
    .chipEnableN(chipEnableN),
    .cmdLatch(cmdLatch),
    .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN),
    .read_strobe_n(read_strobe_n),
    .writeProtectN(writeProtectN),
    .bytePortOut(bytePortOut),
    .failGroups(failGroups),
    .bytePortIn(bytePortIn),
    .ready_busy_n(ready_busy_n)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] o, input logic [7:0] c);
    apb(1'b1, `NOS_REG_CTRL, {8'h00, c, 7'h00, 1'b1, 4'h0, o});
    do
      apb(1'b0, `NOS_REG_STATUS, 32'h0);
    while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c); op(`NOS_OP_CMD, c); endtask
  task automatic rdy(); op(`NOS_OP_WAITRDY, 8'h00); endtask
  task automatic adr(input int blk, input int col);
    apb(1'b1, `NOS_REG_ADDR, 32'((blk << 13) | col));
    op(`NOS_OP_ADDR, 8'h00);
  endtask
  task automatic wrb(input logic [7:0] b);
    apb(1'b1, `NOS_REG_WDATA, {24'h0, b});
    op(`NOS_OP_WRITE, 8'h00);
  endtask
  task automatic rdb(input logic [7:0] exp);
    op(`NOS_OP_READ, 8'h00);
    apb(1'b0, `NOS_REG_RDATA, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic pick(input logic [7:0] c, input int blk, input int col);
    cmd(c);
    adr(blk, col);
    rdy();
  endtask
  task automatic t_regs();
    apb(1'b0, `NOS_REG_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `NOS_REG_CFG, 32'h1);
    @(negedge clock);
    chk({31'h0, writeProtectN}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_prog();
    cmd(8'h80);
    adr(3, 0);
    wrb(8'ha5);
    wrb(8'h3c);
    cmd(8'h10);
    apb(1'b0, `NOS_REG_STATUS, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    rdy();
    cmd(8'h70);
    rdb(8'hc0);
    pick(8'h00, 3, 0);
    rdb(8'ha5);
    rdb(8'h3c);
    $display("test program done");
  endtask
  task automatic t_multi();
    failGroups <= 4'h4;
    cmd(8'h80);
    adr(6, 0);
    wrb(8'h11);
    cmd(8'h11);
    cmd(8'h80);
    adr(4, 0);
    apb(1'b0, `NOS_REG_STATUS, 32'h0);
    chk({28'h0, rd[11:8]}, 32'h5);
    wrb(8'h22);
    cmd(8'h15);
    rdy();
    apb(1'b0, `NOS_REG_STATUS, 32'h0);
    chk({22'h0, rd[29:24], rd[11:8]}, 32'h10);
    cmd(8'h80);
    adr(6, 256);
    wrb(8'h33);
    cmd(8'h10);
    rdy();
    cmd(8'h71);
    rdb(8'hc9);
    $display("test multi program done");
  endtask
  task automatic t_erase();
    failGroups <= 4'h2;
    cmd(8'h60);
    adr(5, 0);
    cmd(8'h60);
    adr(8, 0);
    apb(1'b0, `NOS_REG_STATUS, 32'h0);
    chk({28'h0, rd[11:8]}, 32'h3);
    cmd(8'hd0);
    rdy();
    cmd(8'h71);
    rdb(8'hc5);
    apb(1'b0, `NOS_REG_STATUS, 32'h0);
    chk({24'h0, rd[23:16]}, 32'hc5);
    cmd(8'h70);
    rdb(8'hc1);
    $display("test erase done");
  endtask
  task automatic t_spare();
    cmd(8'h50);
    cmd(8'h80);
    adr(9, 1);
    wrb(8'h5a);
    cmd(8'h10);
    rdy();
    pick(8'h50, 9, 1);
    rdb(8'h5a);
    pick(8'h00, 9, 1);
    rdb(8'hff);
    $display("test spare done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_prog();
    t_multi();
    t_erase();
    t_spare();
    give_verdict();
  end
endmodule // testbench
